//--- common/qet_pkg.sv
// Constants, types and decode helpers shared by the quadrature encoder timer
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Mode field picks x4, x2, timer, off
// - Direction bit one when counting upward
// - Count error flag set on count error
// - Gate bit makes timer count gated time
// - Prescale field divides 1, 8, 64, 256
// - Prescaler used in timer mode only
// - Index clears counter in index modes
// - Clock source: phase A edges or clock
// - Timer direction from phase B or bit
// - Direction bit writable only in timer mode
// - x4 index match needs both phase levels
// - x2 index match picks one phase level
// - Mask bit blocks count error interrupt
// - Filter enable routes pins through filters
// - Filter divide field sets sample rate
// - Unimplemented filter bits read zero
//////////////////////////////////////////////////////////////////////////////
package qet_pkg;

   // Register byte offsets on the APB slave
   localparam logic [7:0] OFF_ENC_CTRL  = 8'h00;
   localparam logic [7:0] OFF_FILT_CTRL = 8'h04;
   localparam logic [7:0] OFF_POS       = 8'h08;
   localparam logic [7:0] OFF_MAX       = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;

   // Mode field codes
   localparam logic [2:0] MODE_X4_MATCH = 3'h7;
   localparam logic [2:0] MODE_X4_INDEX = 3'h6;
   localparam logic [2:0] MODE_X2_MATCH = 3'h5;
   localparam logic [2:0] MODE_X2_INDEX = 3'h4;
   localparam logic [2:0] MODE_TIMER    = 3'h1;

   // Interrupt status bit positions
   localparam int unsigned IRQ_W       = 3;
   localparam int unsigned IRQ_CNT_ERR = 0;
   localparam int unsigned IRQ_WRAP    = 1;
   localparam int unsigned IRQ_INDEX   = 2;

   // Divider ratio width and filter run length
   localparam int unsigned DIV_W       = 9;
   localparam int unsigned FILT_RUN    = 3;

   // Control fields in bit order, msb first
   typedef struct packed {
      logic       cnt_err;     // Count error flag, bit 15
      logic       dir;         // Count direction, bit 11
      logic [2:0] mode;        // Mode select, bits 10:8
      logic       gate;        // Gated accumulation, bit 5
      logic [1:0] presc;       // Timer prescale, bits 4:3
      logic       idx_clr;     // Index clears count, bit 2
      logic       clk_src;     // Timer clock source, bit 1
      logic       dir_src;     // Direction source, bit 0
   } qet_enc_ctrl_t;

   typedef struct packed {
      logic [1:0] ims;         // Index match state, bits 10:9
      logic       ce_mask;     // Count error irq mask, bit 8
      logic       filt_en;     // Filter output enable, bit 7
      logic [2:0] fdiv;        // Filter clock divide, bits 6:4
   } qet_filt_ctrl_t;

   typedef struct packed {
      logic a;                 // Phase A
      logic b;                 // Phase B
      logic idx;               // Index
   } qet_pins_t;

   // Reset values
   localparam qet_enc_ctrl_t  ENC_CTRL_RST = '0;
   localparam qet_filt_ctrl_t FILT_CTRL_RST = '0;
   localparam logic [15:0]    POS_RST = 16'h0000;
   localparam logic [15:0]    MAX_RST = 16'hFFFF;

   // Timer prescale ratio
   function automatic logic [DIV_W-1:0] presc_ratio(input logic [1:0] sel);
      unique case (sel)
         2'h3:    presc_ratio = 9'h100;
         2'h2:    presc_ratio = 9'h040;
         2'h1:    presc_ratio = 9'h008;
         default: presc_ratio = 9'h001;
      endcase
   endfunction

   // Filter sample clock ratio
   function automatic logic [DIV_W-1:0] fdiv_ratio(input logic [2:0] sel);
      unique case (sel)
         3'h7:    fdiv_ratio = 9'h100;
         3'h6:    fdiv_ratio = 9'h080;
         3'h5:    fdiv_ratio = 9'h040;
         3'h4:    fdiv_ratio = 9'h020;
         3'h3:    fdiv_ratio = 9'h010;
         3'h2:    fdiv_ratio = 9'h004;
         3'h1:    fdiv_ratio = 9'h002;
         default: fdiv_ratio = 9'h001;
      endcase
   endfunction

endpackage

//--- core/qet_tick_div.sv
// Event divider that emits one tick per ratio input events
`timescale 1ns/1ps
`default_nettype none
module qet_tick_div
   import qet_pkg::*;
#(
   parameter int unsigned W = DIV_W      // Counter width
) (
   input  wire logic         pclk,       // Clock
   input  wire logic         presetn,    // Async reset, active low
   input  wire logic         clear,      // Restart count
   input  wire logic         event_in,   // Event to divide
   input  wire logic [W-1:0] ratio,      // Events per tick
   output logic              tick        // One-cycle tick
);

   logic [W-1:0] cnt_q;                  // Events seen so far

   // Count events; ratio of one gives a tick on every event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (clear) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (event_in) begin
         if (cnt_q >= ratio - W'(1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
         end else begin
            cnt_q <= cnt_q + W'(1);
            tick  <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

//--- core/qet_glitch_filt.sv
// Digital glitch filter for one synchronised pin
`timescale 1ns/1ps
`default_nettype none
module qet_glitch_filt
   import qet_pkg::*;
#(
   parameter int unsigned RUN = FILT_RUN  // Stable samples needed
) (
   input  wire logic pclk,               // Clock
   input  wire logic presetn,            // Async reset, active low
   input  wire logic sample,             // Filter sample tick
   input  wire logic raw,                // Synchronised pin level
   output logic      filt_q              // Filtered level
);

   logic [$clog2(RUN+1)-1:0] run_q;      // Samples differing from output

   // Output follows only after RUN samples in a row disagree with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q  <= '0;
         filt_q <= 1'b0;
      end else if (sample) begin
         if (raw == filt_q) begin
            run_q <= '0;
         end else if (run_q == ($clog2(RUN+1))'(RUN - 1)) begin
            run_q  <= '0;
            filt_q <= raw;
         end else begin
            run_q <= run_q + ($clog2(RUN+1))'(1);
         end
      end
   end

endmodule
`default_nettype wire

//--- core/qet_top.sv
// Quadrature encoder interface with alternate timer mode and APB registers
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module qet_top
   import qet_pkg::*;
#(
   parameter int unsigned CNT_W = 16     // Position counter width
) (
   input  wire logic        pclk,        // APB clock, 40 MHz
   input  wire logic        presetn,     // Async reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB access phase
   input  wire logic        pwrite,      // APB write
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic [31:0]      prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error, unmapped address
   input  wire logic        phase_a_in,  // Encoder phase A pin
   input  wire logic        phase_b_in,  // Encoder phase B pin
   input  wire logic        index_in,    // Encoder index pin
   output logic             irq          // Level interrupt
);

   //////////////////////////////////////////////////////////////////////////
   // Declarations
   //////////////////////////////////////////////////////////////////////////
   qet_enc_ctrl_t    enc_q;              // Encoder control
   qet_filt_ctrl_t   filt_ctrl_q;        // Filter control
   logic [CNT_W-1:0] position_counter_q; // Position or timer count
   logic [CNT_W-1:0] max_count_limit_q;  // Match / period value
   logic [IRQ_W-1:0] irq_stat_q;         // Sticky events
   logic [IRQ_W-1:0] irq_mask_q;         // Event enables
   qet_pins_t        sync1_q;            // First synchroniser stage
   qet_pins_t        sync2_q;            // Second synchroniser stage
   qet_pins_t        filt_out;           // Filter outputs
   qet_pins_t        pins_q;             // Selected pin levels
   qet_pins_t        prev_q;             // Levels one cycle earlier
   logic             fsample;            // Filter sample tick
   logic             tmr_tick;           // Prescaled timer tick
   logic             tmr_evt;            // Timer input event
   logic             is_quad;            // Any quadrature mode
   logic             is_x4;              // x4 modes
   logic             is_match;           // Match reset modes
   logic             is_index;           // Index reset modes
   logic             is_timer;           // Timer mode
   logic             a_chg;              // Phase A changed
   logic             b_chg;              // Phase B changed
   logic             q_step;             // Quadrature count step
   logic             q_up;               // Quadrature step direction
   logic             q_err;              // Both phases moved at once
   logic             idx_rise;           // Index rising edge
   logic             idx_hit;            // Index qualified by match
   logic             step;               // Counter steps this cycle
   logic             step_up;            // Direction of that step
   logic             at_wrap;            // Step hits the wrap value
   logic [IRQ_W-1:0] evt;                // Events this cycle
   logic             wr_acc;             // Completing write
   logic             rd_acc;             // Completing read
   logic [31:0]      rd_val;             // Read mux
   logic             rd_hit;             // Address is mapped

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, filters and selection
   //////////////////////////////////////////////////////////////////////////

   // Two flops per pin; the first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= '{a: phase_a_in, b: phase_b_in, idx: index_in};
         sync2_q <= sync1_q;
      end
   end

   // Shared sample clock for all three filters
   qet_tick_div #(
      .W        (DIV_W)
   ) u_fdiv (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (!filt_ctrl_q.filt_en),
      .event_in (1'b1),
      .ratio    (fdiv_ratio(filt_ctrl_q.fdiv)),
      .tick     (fsample)
   );

   // One filter per pin
   for (genvar i = 0; i < 3; i++) begin : g_filt
      qet_glitch_filt #(
         .RUN     (FILT_RUN)
      ) u_filt (
         .pclk    (pclk),
         .presetn (presetn),
         .sample  (fsample),
         .raw     (sync2_q[i]),
         .filt_q  (filt_out[i])
      );
   end

   // Filtered or direct levels, then one more stage for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_q <= '0;
         prev_q <= '0;
      end else begin
         pins_q <= filt_ctrl_q.filt_en ? filt_out : sync2_q;
         prev_q <= pins_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Mode decode and quadrature decode
   //////////////////////////////////////////////////////////////////////////

   // Codes 010 and 011 fall through as disabled, like 000
   always_comb begin
      is_quad  = enc_q.mode[2];
      is_x4    = enc_q.mode[2] && enc_q.mode[1];
      is_match = enc_q.mode[2] && enc_q.mode[0];
      is_index = enc_q.mode[2] && !enc_q.mode[0];
      is_timer = (enc_q.mode == MODE_TIMER);
   end

   // x4 counts every phase edge, x2 only phase A edges
   always_comb begin
      a_chg   = pins_q.a ^ prev_q.a;
      b_chg   = pins_q.b ^ prev_q.b;
      q_err   = is_quad && a_chg && b_chg;
      q_step  = is_quad && !q_err && (is_x4 ? (a_chg || b_chg) : a_chg);
      q_up    = pins_q.a ^ prev_q.b;
   end

   // Index edge qualified by the phase levels
   always_comb begin
      idx_rise = pins_q.idx && !prev_q.idx;
      if (is_x4) begin
         idx_hit = (pins_q.b == filt_ctrl_q.ims[1])
                   && (pins_q.a == filt_ctrl_q.ims[0]);
      end else begin
         idx_hit = ((filt_ctrl_q.ims[1] ? pins_q.b : pins_q.a)
                    == filt_ctrl_q.ims[0]);
      end
      idx_hit = idx_hit && idx_rise && is_index && enc_q.idx_clr;
   end

   //////////////////////////////////////////////////////////////////////////
   // Timer input and prescaler
   //////////////////////////////////////////////////////////////////////////

   // Phase A edges, gated clock, or plain clock
   always_comb begin
      if (enc_q.clk_src) begin
         tmr_evt = pins_q.a && !prev_q.a;
      end else if (enc_q.gate) begin
         tmr_evt = pins_q.a;
      end else begin
         tmr_evt = 1'b1;
      end
   end

   // Held clear outside timer mode so quadrature counts bypass it
   qet_tick_div #(
      .W        (DIV_W)
   ) u_presc (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (!is_timer),
      .event_in (tmr_evt),
      .ratio    (presc_ratio(enc_q.presc)),
      .tick     (tmr_tick)
   );

   // Step source and direction for the shared counter
   always_comb begin
      if (is_timer) begin
         step    = tmr_tick;
         step_up = enc_q.dir_src ? pins_q.b : enc_q.dir;
      end else begin
         step    = q_step;
         step_up = q_up;
      end
      at_wrap = step_up ? (position_counter_q == max_count_limit_q)
                        : (position_counter_q == '0);
   end

   //////////////////////////////////////////////////////////////////////////
   // APB slave
   //////////////////////////////////////////////////////////////////////////

   // Transfers finish in the access phase after a single setup cycle
   always_comb begin
      wr_acc = psel && penable && pready && pwrite;
      rd_acc = psel && penable && pready && !pwrite;
   end

   // Read mux; unlisted bits read as zero
   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      unique case (paddr)
         OFF_ENC_CTRL: begin
            rd_val[15]  = enc_q.cnt_err;
            rd_val[11]  = enc_q.dir;
            rd_val[10:8] = enc_q.mode;
            rd_val[5:0] = {enc_q.gate, enc_q.presc, enc_q.idx_clr,
                           enc_q.clk_src, enc_q.dir_src};
         end
         OFF_FILT_CTRL: rd_val[10:4] = filt_ctrl_q;
         OFF_POS:       rd_val[CNT_W-1:0] = position_counter_q;
         OFF_MAX:       rd_val[CNT_W-1:0] = max_count_limit_q;
         OFF_IRQ_STAT:  rd_val[IRQ_W-1:0] = irq_stat_q;
         OFF_IRQ_MASK:  rd_val[IRQ_W-1:0] = irq_mask_q;
         default:       rd_hit = 1'b0;
      endcase
   end

   // Registered answer captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= !rd_hit;
         prdata  <= (rd_hit && !pwrite) ? rd_val : '0;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Control registers
   //////////////////////////////////////////////////////////////////////////

   // Encoder control; error flag and direction also move by hardware
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enc_q <= ENC_CTRL_RST;
      end else begin
         if (wr_acc && paddr == OFF_ENC_CTRL) begin
            enc_q.cnt_err <= pwdata[15];
            enc_q.mode    <= pwdata[10:8];
            enc_q.gate    <= pwdata[5];
            enc_q.presc   <= pwdata[4:3];
            enc_q.idx_clr <= pwdata[2];
            enc_q.clk_src <= pwdata[1];
            enc_q.dir_src <= pwdata[0];
            if (is_timer) begin
               enc_q.dir <= pwdata[11];
            end
         end
         // Hardware set wins over a software clear in the same cycle
         if (q_err) begin
            enc_q.cnt_err <= 1'b1;
         end
         if (q_step) begin
            enc_q.dir <= q_up;
         end else if (is_timer && enc_q.dir_src) begin
            enc_q.dir <= pins_q.b;
         end
      end
   end

   // Filter control, only bits 10:4 stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_ctrl_q <= FILT_CTRL_RST;
      end else if (wr_acc && paddr == OFF_FILT_CTRL) begin
         filt_ctrl_q <= pwdata[10:4];
      end
   end

   // Match value; doubles as timer period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         max_count_limit_q <= MAX_RST;
      end else if (wr_acc && paddr == OFF_MAX) begin
         max_count_limit_q <= pwdata[CNT_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Position counter
   //////////////////////////////////////////////////////////////////////////

   // Software write beats index clear, which beats a count step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         position_counter_q <= POS_RST;
      end else if (wr_acc && paddr == OFF_POS) begin
         position_counter_q <= pwdata[CNT_W-1:0];
      end else if (idx_hit) begin
         position_counter_q <= '0;
      end else if (step) begin
         // Index modes wrap at full range; match and timer at the limit
         if (at_wrap && (is_match || is_timer)) begin
            position_counter_q <= step_up ? '0 : max_count_limit_q;
         end else if (step_up) begin
            position_counter_q <= position_counter_q + CNT_W'(1);
         end else begin
            position_counter_q <= position_counter_q - CNT_W'(1);
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupts
   //////////////////////////////////////////////////////////////////////////

   // Events this cycle
   always_comb begin
      evt              = '0;
      evt[IRQ_CNT_ERR] = q_err;
      evt[IRQ_WRAP]    = step && at_wrap && (is_match || is_timer);
      evt[IRQ_INDEX]   = idx_hit;
   end

   // Read clears only bits that were returned, so new events survive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
      end else if (rd_acc && paddr == OFF_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~prdata[IRQ_W-1:0]) | evt;
      end else begin
         irq_stat_q <= irq_stat_q | evt;
      end
   end

   // Mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= '0;
      end else if (wr_acc && paddr == OFF_IRQ_MASK) begin
         irq_mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // Count error needs both its mask bit and a clear disable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q
                  & ~{{(IRQ_W-1){1'b0}}, filt_ctrl_q.ce_mask});
      end
   end

endmodule
`default_nettype wire

//--- bench/qet_enc_model.sv
// Behavioural incremental encoder with two phases and an index
`timescale 1ns/1ps
`default_nettype none
module qet_enc_model (
   input  wire logic       pclk,     // Clock
   input  wire logic       presetn,  // Reset, active low
   input  wire logic [1:0] cmd,      // 1 forward, 2 back, 3 both phases
   input  wire logic       idx_req,  // Wanted index level
   output logic            phase_a,  // Phase A pin
   output logic            phase_b,  // Phase B pin
   output logic            index     // Index pin
);
   // Gray walk; forward means A leads B, a 3 breaks the code on purpose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {phase_a, phase_b} <= 2'h0;
      end else begin
         case (cmd)
            2'h1:    {phase_a, phase_b} <= {~phase_b, phase_a};
            2'h2:    {phase_a, phase_b} <= {phase_b, ~phase_a};
            2'h3:    {phase_a, phase_b} <= ~{phase_a, phase_b};
            default: ;
         endcase
      end
   end
   // Index pin follows the bench request
   assign index = idx_req;
endmodule
`default_nettype wire

//--- bench/qet_top_assertions.sv
// Port-level checker for the quadrature encoder timer block
`timescale 1ns/1ps
`default_nettype none
module qet_top_assertions
   import qet_pkg::*;
#(
   parameter int unsigned CNT_W = 16     // Position counter width
) (
   input wire logic        pclk,         // Clock
   input wire logic        presetn,      // Reset, active low
   input wire logic        psel,         // APB select
   input wire logic        penable,      // APB access phase
   input wire logic        pwrite,       // APB write
   input wire logic [7:0]  paddr,        // APB address
   input wire logic [31:0] pwdata,       // APB write data
   input wire logic [31:0] prdata,       // APB read data
   input wire logic        pready,       // APB ready
   input wire logic        pslverr,      // APB error
   input wire logic        phase_a_in,   // Phase A pin
   input wire logic        phase_b_in,   // Phase B pin
   input wire logic        index_in,     // Index pin
   input wire logic        irq           // Interrupt
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Setup cycle, then a read answer from a given place
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd_filt;
      s_setup ##1 (pready && !pwrite && paddr == OFF_FILT_CTRL);
   endsequence
   chk_ready_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside access");
   chk_high_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   chk_filt_zero: assert property (
      s_rd_filt |-> prdata[15:11] == 5'h0 && prdata[3:0] == 4'h0)
      else $error("unused filter bits set");
   chk_enc_zero: assert property (pready && !pwrite && paddr == OFF_ENC_CTRL
      |-> prdata[14:12] == 3'h0 && prdata[7:6] == 2'h0)
      else $error("unused control bits set");
   chk_map_err: assert property (s_setup ##1 (pready && paddr > OFF_IRQ_MASK) |-> pslverr)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire
bind qet_top qet_top_assertions #(.CNT_W(CNT_W)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_in(phase_a_in),
   .phase_b_in(phase_b_in), .index_in(index_in), .irq(irq));

//--- bench/quadrature_encoder_timer_control_tb.sv
// Self-checking bench for the quadrature encoder timer block
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_timer_control_tb
   import qet_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0;            // Clock and reset
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
   logic [7:0]  paddr = 8'h00;                          // APB address
   logic [31:0] pwdata = 32'h0000_0000, prdata;         // APB data
   logic        pready, pslverr, irq, pa, pb, pi;       // Outputs and pins
   logic [1:0]  cmd = 2'h0;                             // Encoder command
   logic        idx_req = 1'b0;                         // Index request
   logic [32:0] exp_q[$];                               // Expected reads
   int          n_fail = 0, n_tests = 0, n, seed = 32'h1ab4829f;
   always #12.5 pclk = ~pclk;
   qet_enc_model enc_u (.pclk(pclk), .presetn(presetn), .cmd(cmd), .idx_req(idx_req),
      .phase_a(pa), .phase_b(pb), .index(pi));
   qet_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phase_a_in(pa), .phase_b_in(pb), .index_in(pi), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer; the edge after release is let pass
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      if (!w) exp_q.push_back(e);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0000_0000, e);
   endtask
   // One encoder move, then time for sync and filter to pass it on
   task automatic step(input logic [1:0] c);
      cmd <= c;
      @(posedge pclk);
      cmd <= 2'h0;
      repeat (24) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Read results are compared in arrival order
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("apb_read", {pslverr, prdata}, exp_q.pop_front());
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFF_ENC_CTRL, 33'h0);
      rd(OFF_FILT_CTRL, 33'h0);
      rd(OFF_MAX, 33'hFFFF);
      rd(8'h20, 33'h1_0000_0000);
      wr(OFF_FILT_CTRL, 32'h0000_FFFF);
      rd(OFF_FILT_CTRL, 33'h7F0);
      wr(OFF_FILT_CTRL, 32'h0000_0000);
      wr(OFF_ENC_CTRL, 32'h0000_0902);
      rd(OFF_ENC_CTRL, 33'h102);
      // Timer on phase A rising edges, count up, prescale off
      wr(OFF_ENC_CTRL, 32'h0000_0902);
      rd(OFF_ENC_CTRL, 33'h902);
      wr(OFF_POS, 32'h0000_0000);
      repeat (8) step(2'h1);
      rd(OFF_POS, 33'h2);
      // x4 decode through the filters at a random distance
      wr(OFF_ENC_CTRL, 32'h0000_0700);
      wr(OFF_FILT_CTRL, 32'h0000_0090);
      wr(OFF_POS, 32'h0000_0000);
      n = 1 + ($unsigned($random(seed)) % 8);
      repeat (n) step(2'h1);
      rd(OFF_POS, {17'h0, 16'(n)});
      rd(OFF_ENC_CTRL, 33'hF00);
      step(2'h2);
      rd(OFF_POS, {17'h0, 16'(n - 1)});
      rd(OFF_ENC_CTRL, 33'h700);
      // Both phases at once is a count error
      wr(OFF_IRQ_MASK, 32'h0000_0001);
      step(2'h3);
      chk("irq_err", {32'h0, irq}, 33'h1);
      rd(OFF_ENC_CTRL, 33'h8700);
      wr(OFF_FILT_CTRL, 32'h0000_0190);
      repeat (3) @(posedge pclk);
      chk("irq_masked", {32'h0, irq}, 33'h0);
      rd(OFF_IRQ_STAT, 33'h1);
      rd(OFF_IRQ_STAT, 33'h0);
      // Index clear needs both phases low and the enable set
      wr(OFF_FILT_CTRL, 32'h0000_0000);
      while (pa | pb) step(2'h1);
      wr(OFF_ENC_CTRL, 32'h0000_0600);
      wr(OFF_POS, 32'h0000_0055);
      idx_req <= 1'b1;
      repeat (8) @(posedge pclk);
      idx_req <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OFF_POS, 33'h55);
      wr(OFF_ENC_CTRL, 32'h0000_0604);
      idx_req <= 1'b1;
      repeat (8) @(posedge pclk);
      idx_req <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OFF_POS, 33'h0);
      repeat (3) @(posedge pclk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
